// >>> pkg/e1c_consts.vh
`ifndef E1C_CONSTS_VH
`define E1C_CONSTS_VH

// Register offsets on the host control port
`define E1C_ADDR_AMP_SCALE 8'h07
`define E1C_ADDR_TRAM_CTRL 8'h08
`define E1C_ADDR_TRAM_DATA 8'h09
`define E1C_ADDR_RX_CFG 8'h0a

// Reset values
`define E1C_RST_AMP_SCALE 6'h21
`define E1C_RST_TRAM_CTRL 8'h00
`define E1C_RST_TRAM_DATA 7'h00
`define E1C_RST_RX_CFG 5'h00

// Indirect access control fields
`define E1C_CTRL_GO_BIT 7
`define E1C_CTRL_DIR_BIT 6
`define E1C_CTRL_UI_MSB 5
`define E1C_CTRL_UI_LSB 4
`define E1C_CTRL_SAMPLE_SEL_MSB 3
`define E1C_CTRL_SAMPLE_SEL_LSB 0

// Receive configuration fields
`define E1C_RX_OFF_BIT 4
`define E1C_RX_INV_BIT 3
`define E1C_RX_EDGE_BIT 2
`define E1C_RX_MODE_MSB 1
`define E1C_RX_MODE_LSB 0

// Receive decode modes
`define E1C_MODE_HDB3 2'h0
`define E1C_MODE_AMI 2'h1
`define E1C_MODE_DUAL 2'h2
`define E1C_MODE_SLICER 2'h3

// Scale arithmetic: amplitude * scale * 31 / 1024 ~= amplitude * scale / 33
`define E1C_SCALE_MULT 5'h1f
`define E1C_SCALE_SHIFT 10

`endif

// >>> hdl/e1c_template_ram.v
`timescale 1ns/1ns
module e1c_template_ram
#(
   parameter AW = 6,
   parameter DW = 7
)
(
   input wire clk_in,
   input wire wr_en_in,
   input wire [AW-1:0] wr_addr_in,
   input wire [DW-1:0] wr_data_in,
   input wire [AW-1:0] rd_addr_in,
   output reg [DW-1:0] rd_data_out,
   input wire [AW-1:0] shp_addr_in,
   output reg [DW-1:0] shp_data_out
);

reg [DW-1:0] mem [0:(1<<AW)-1];

// -----------------------------------------------------------------
// One write port, two registered read ports
// -----------------------------------------------------------------
always @(posedge clk_in)
begin
   if (wr_en_in)
   begin
      mem[wr_addr_in] <= wr_data_in;
   end
   rd_data_out <= mem[rd_addr_in];
   shp_data_out <= mem[shp_addr_in];
end

endmodule

// >>> hdl/e1c_top.v
// How it works
// [R1] Six-bit amplitude scale, reset 100001, scales programmable pulse samples.
// [R2] One scale step changes pulse amplitude by about three percent.
// [R3] Writing one to control bit 7 starts one template RAM access.
// [R4] Control bit 6 picks direction: zero writes, one reads.
// [R5] Control bits 5-4 pick the unit interval, 00 leftmost.
// [R6] Control bits 3-0 pick the sample in the interval, 0 leftmost.
// [R7] Indirect write stores data register bits 6-0 into the sample.
// [R8] Indirect read returns the sample into the data register.
// [R9] Receive config bit 4 powers the receiver down.
// [R10] Receive config bit 3 makes receive outputs active low.
// [R11] Receive config bit 2 picks rising or falling recovered clock edge.
// [R12] Edge select is ignored in slicer mode.
// [R13] Mode 00 decodes HDB3 to single-rail NRZ.
// [R14] Mode 01 decodes AMI to single-rail NRZ.
// [R15] Mode 10 gives retimed dual-rail NRZ, decoder bypassed.
// [R16] Mode 11 gives raw slicer RZ data on the dual rails.
// [R17] Software sets up fields first and runs one access at a time.
// [R18] Template RAM has 64 seven-bit words, index is interval*16+sample.
`timescale 1ns/1ns
`include "e1c_consts.vh"
module e1c_top
#(
   parameter SCALE_W = 6,
   parameter AMP_W = 7,
   parameter TRAM_AW = 6
)
(
   input wire clk_in,
   input wire rstn_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [7:0] reg_rdata_out,
   input wire [TRAM_AW-1:0] shp_addr_in,
   output reg [AMP_W:0] shp_amp_out,
   input wire slicer_pos_in,
   input wire slicer_neg_in,
   input wire rx_rec_clk_in,
   output reg rx_data_out,
   output reg rx_positive_rail_out,
   output reg rx_negative_rail_out,
   output wire rx_powerdown_out
);

localparam PROD_W = AMP_W + SCALE_W + 5;

// -----------------------------------------------------------------
// Scaling of a signed template sample
// -----------------------------------------------------------------
function [AMP_W:0] scale_amp;
   input [AMP_W-1:0] amp;
   input [SCALE_W-1:0] scl;
   reg signed [PROD_W-1:0] prod;
   begin
      prod = $signed({{(PROD_W-AMP_W){amp[AMP_W-1]}}, amp})
         * $signed({{(PROD_W-SCALE_W){1'b0}}, scl})
         * $signed({{(PROD_W-5){1'b0}}, `E1C_SCALE_MULT});
      scale_amp = prod[`E1C_SCALE_SHIFT+AMP_W:`E1C_SCALE_SHIFT];
   end
endfunction

// -----------------------------------------------------------------
// Register state
// -----------------------------------------------------------------
reg [SCALE_W-1:0] scale_ff;
reg [7:0] ctrl_ff;
reg [AMP_W-1:0] tdata_ff;
reg [4:0] rxcfg_ff;
reg rd_pend_ff;
reg [AMP_W-1:0] nxt_tdata;
reg [7:0] nxt_ctrl;

wire wr_scale = reg_wr_in && (reg_addr_in == `E1C_ADDR_AMP_SCALE);
wire wr_ctrl = reg_wr_in && (reg_addr_in == `E1C_ADDR_TRAM_CTRL);
wire wr_tdata = reg_wr_in && (reg_addr_in == `E1C_ADDR_TRAM_DATA);
wire wr_rxcfg = reg_wr_in && (reg_addr_in == `E1C_ADDR_RX_CFG);

wire go = ctrl_ff[`E1C_CTRL_GO_BIT];
wire dir_rd = ctrl_ff[`E1C_CTRL_DIR_BIT];
wire [TRAM_AW-1:0] tram_addr =
   {ctrl_ff[`E1C_CTRL_UI_MSB:`E1C_CTRL_UI_LSB],
    ctrl_ff[`E1C_CTRL_SAMPLE_SEL_MSB:`E1C_CTRL_SAMPLE_SEL_LSB]}; // [R5] [R6] [R18]
wire tram_we = go && !dir_rd; // [R4] [R7]
wire [AMP_W-1:0] tram_rd_data;
wire [AMP_W-1:0] shp_raw;

e1c_template_ram
#(
   .AW(TRAM_AW),
   .DW(AMP_W)
)
e1c_template_ram_inst
(
   .clk_in(clk_in),
   .wr_en_in(tram_we),
   .wr_addr_in(tram_addr),
   .wr_data_in(tdata_ff),
   .rd_addr_in(tram_addr),
   .rd_data_out(tram_rd_data),
   .shp_addr_in(shp_addr_in),
   .shp_data_out(shp_raw)
);

// -----------------------------------------------------------------
// Indirect access sequencing
// -----------------------------------------------------------------
// Go bit stays set for the one cycle the access takes, then clears.
always @*
begin
   nxt_ctrl = ctrl_ff;
   if (go)
   begin
      nxt_ctrl[`E1C_CTRL_GO_BIT] = 1'b0;
   end
   if (wr_ctrl)
   begin
      nxt_ctrl = reg_wdata_in; // [R3]
   end
end

// Read result wins over a software write to the data register.
always @*
begin
   nxt_tdata = tdata_ff;
   if (wr_tdata)
   begin
      nxt_tdata = reg_wdata_in[AMP_W-1:0];
   end
   if (rd_pend_ff)
   begin
      nxt_tdata = tram_rd_data; // [R8]
   end
end

always @(posedge clk_in or negedge rstn_in)
begin
   if (!rstn_in)
   begin
      scale_ff <= `E1C_RST_AMP_SCALE;
      ctrl_ff <= `E1C_RST_TRAM_CTRL;
      tdata_ff <= `E1C_RST_TRAM_DATA;
      rxcfg_ff <= `E1C_RST_RX_CFG;
      rd_pend_ff <= 1'b0;
   end
   else
   begin
      if (wr_scale)
      begin
         scale_ff <= reg_wdata_in[SCALE_W-1:0]; // [R1]
      end
      if (wr_rxcfg)
      begin
         rxcfg_ff <= reg_wdata_in[4:0];
      end
      ctrl_ff <= nxt_ctrl;
      tdata_ff <= nxt_tdata;
      rd_pend_ff <= go && dir_rd; // [R4]
   end
end

// -----------------------------------------------------------------
// Register readback
// -----------------------------------------------------------------
always @(posedge clk_in or negedge rstn_in)
begin
   if (!rstn_in)
   begin
      reg_rdata_out <= 8'h00;
   end
   else if (reg_rd_in)
   begin
      case (reg_addr_in)
         `E1C_ADDR_AMP_SCALE:
            reg_rdata_out <= {2'h0, scale_ff};
         `E1C_ADDR_TRAM_CTRL:
            reg_rdata_out <= ctrl_ff;
         `E1C_ADDR_TRAM_DATA:
            reg_rdata_out <= {1'b0, tdata_ff};
         `E1C_ADDR_RX_CFG:
            reg_rdata_out <= {3'h0, rxcfg_ff};
         default:
            reg_rdata_out <= 8'h00;
      endcase
   end
end

// -----------------------------------------------------------------
// Scaled template sample for the waveform shaper
// -----------------------------------------------------------------
always @(posedge clk_in or negedge rstn_in)
begin
   if (!rstn_in)
   begin
      shp_amp_out <= {(AMP_W+1){1'b0}};
   end
   else
   begin
      shp_amp_out <= scale_amp(shp_raw, scale_ff); // [R1] [R2]
   end
end

// -----------------------------------------------------------------
// Receive input synchronisers
// -----------------------------------------------------------------
reg pos_s1_ff;
reg pos_s2_ff;
reg neg_s1_ff;
reg neg_s2_ff;
reg rck_s1_ff;
reg rck_s2_ff;
reg rck_s3_ff;

always @(posedge clk_in or negedge rstn_in)
begin
   if (!rstn_in)
   begin
      pos_s1_ff <= 1'b0;
      pos_s2_ff <= 1'b0;
      neg_s1_ff <= 1'b0;
      neg_s2_ff <= 1'b0;
      rck_s1_ff <= 1'b0;
      rck_s2_ff <= 1'b0;
      rck_s3_ff <= 1'b0;
   end
   else
   begin
      pos_s1_ff <= slicer_pos_in;
      pos_s2_ff <= pos_s1_ff;
      neg_s1_ff <= slicer_neg_in;
      neg_s2_ff <= neg_s1_ff;
      rck_s1_ff <= rx_rec_clk_in;
      rck_s2_ff <= rck_s1_ff;
      rck_s3_ff <= rck_s2_ff;
   end
end

// -----------------------------------------------------------------
// Receive decode
// -----------------------------------------------------------------
reg seen_ff;
reg last_pos_ff;
reg [3:0] dl_ff;

wire rx_off = rxcfg_ff[`E1C_RX_OFF_BIT];
wire rx_inv = rxcfg_ff[`E1C_RX_INV_BIT];
wire edge_fall = rxcfg_ff[`E1C_RX_EDGE_BIT];
wire [1:0] rx_mode = rxcfg_ff[`E1C_RX_MODE_MSB:`E1C_RX_MODE_LSB];
wire rck_rise = rck_s2_ff && !rck_s3_ff;
wire rck_fall = !rck_s2_ff && rck_s3_ff;
wire tick = edge_fall ? rck_fall : rck_rise; // [R11]
wire mark = pos_s2_ff ^ neg_s2_ff;
wire viol = mark && seen_ff && (pos_s2_ff == last_pos_ff);
wire hdb3 = (rx_mode == `E1C_MODE_HDB3);
wire kill = hdb3 && viol; // [R13]

assign rx_powerdown_out = rx_off; // [R9]

// Four-bit line lets B00V / 000V be removed before the bits leave.
always @(posedge clk_in or negedge rstn_in)
begin
   if (!rstn_in)
   begin
      seen_ff <= 1'b0;
      last_pos_ff <= 1'b0;
      dl_ff <= 4'h0;
   end
   else if (rx_off) // [R9]
   begin
      seen_ff <= 1'b0;
      last_pos_ff <= 1'b0;
      dl_ff <= 4'h0;
   end
   else if (tick)
   begin
      if (mark)
      begin
         seen_ff <= 1'b1;
         last_pos_ff <= pos_s2_ff;
      end
      dl_ff <= {dl_ff[2:0] & {3{!kill}}, mark && !kill}; // [R13] [R14]
   end
end

// -----------------------------------------------------------------
// Receive outputs
// -----------------------------------------------------------------
always @(posedge clk_in or negedge rstn_in)
begin
   if (!rstn_in)
   begin
      rx_data_out <= 1'b0;
      rx_positive_rail_out <= 1'b0;
      rx_negative_rail_out <= 1'b0;
   end
   else if (rx_off)
   begin
      rx_data_out <= rx_inv; // [R9] [R10]
      rx_positive_rail_out <= rx_inv;
      rx_negative_rail_out <= rx_inv;
   end
   else
   begin
      case (rx_mode)
         `E1C_MODE_HDB3, `E1C_MODE_AMI:
         begin
            if (tick)
            begin
               rx_data_out <= dl_ff[3] ^ rx_inv; // [R13] [R14] [R10]
            end
            rx_positive_rail_out <= rx_inv;
            rx_negative_rail_out <= rx_inv;
         end
         `E1C_MODE_DUAL:
         begin
            if (tick)
            begin
               rx_positive_rail_out <= pos_s2_ff ^ rx_inv; // [R15] [R10]
               rx_negative_rail_out <= neg_s2_ff ^ rx_inv; // [R15]
            end
            rx_data_out <= rx_inv;
         end
         `E1C_MODE_SLICER:
         begin
            rx_positive_rail_out <= pos_s2_ff ^ rx_inv; // [R16] [R12]
            rx_negative_rail_out <= neg_s2_ff ^ rx_inv; // [R16]
            rx_data_out <= rx_inv;
         end
         default:
         begin
            rx_data_out <= rx_inv;
         end
      endcase
   end
end

endmodule

// >>> test/e1c_top_chk.sv
`timescale 1ns/1ns
module e1c_top_chk
#(
   parameter SCALE_W = 6,
   parameter AMP_W = 7,
   parameter TRAM_AW = 6
)
(
   input wire clk_in,
   input wire rstn_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_rdata_out,
   input wire [TRAM_AW-1:0] shp_addr_in,
   input wire [AMP_W:0] shp_amp_out,
   input wire slicer_pos_in,
   input wire slicer_neg_in,
   input wire rx_rec_clk_in,
   input wire rx_data_out,
   input wire rx_positive_rail_out,
   input wire rx_negative_rail_out,
   input wire rx_powerdown_out
);
   // ------------------------------------------
   // Shadow registers and settle counter
   // ------------------------------------------
   reg [5:0] scl_ff;
   reg [4:0] cfg_ff;
   reg [1:0] sl_ff;
   reg [3:0] cnt_ff;
   wire wr_cfg = reg_wr_in && reg_addr_in == 8'h0a;
   wire [1:0] sl = {slicer_pos_in, slicer_neg_in};
   wire inv = cfg_ff[3];
   wire hit = reg_addr_in >= 8'h07 && reg_addr_in <= 8'h0a;
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         scl_ff <= 6'h21;
         cfg_ff <= 5'h00;
         sl_ff <= 2'h0;
         cnt_ff <= 4'h0;
      end
      else
      begin
         if (reg_wr_in && reg_addr_in == 8'h07)
            scl_ff <= reg_wdata_in[5:0];
         if (wr_cfg)
            cfg_ff <= reg_wdata_in[4:0];
         sl_ff <= sl;
         if (wr_cfg || sl_ff != sl)
            cnt_ff <= 4'h0;
         else if (cnt_ff != 4'hf)
            cnt_ff <= cnt_ff + 4'h1;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   a_scale_read: assert property (reg_rd_in && reg_addr_in == 8'h07 |=>
      reg_rdata_out == {2'h0, $past(scl_ff)}) else $error("scale readback");
   a_cfg_read: assert property (reg_rd_in && reg_addr_in == 8'h0a |=>
      reg_rdata_out == {3'h0, $past(cfg_ff)}) else $error("rx cfg readback");
   a_data_rsvd: assert property (reg_rd_in && reg_addr_in == 8'h09 |=>
      !reg_rdata_out[7]) else $error("data bit 7 set");
   a_unmapped_rd: assert property (reg_rd_in && !hit |=>
      reg_rdata_out == 8'h00) else $error("unmapped read nonzero");
   a_rd_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved");
   a_pd_level: assert property (rx_powerdown_out == cfg_ff[4])
      else $error("power down level");
   a_pd_idle: assert property (cfg_ff[4] && cnt_ff > 4'h7 |->
      {rx_data_out, rx_positive_rail_out, rx_negative_rail_out} == {3{inv}})
      else $error("outputs active in power down");
   a_slicer_rail: assert property (cfg_ff == {1'b0, cfg_ff[3:2], 2'h3} &&
      cnt_ff > 4'h7 |-> rx_data_out == inv &&
      rx_positive_rail_out == ((slicer_pos_in & ~slicer_neg_in) ^ inv) &&
      rx_negative_rail_out == ((slicer_neg_in & ~slicer_pos_in) ^ inv))
      else $error("slicer rails wrong");
endmodule
bind e1c_top e1c_top_chk #(.SCALE_W(SCALE_W), .AMP_W(AMP_W),
   .TRAM_AW(TRAM_AW)) e1c_top_chk_inst (.clk_in(clk_in), .rstn_in(rstn_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .shp_addr_in(shp_addr_in),
   .shp_amp_out(shp_amp_out), .slicer_pos_in(slicer_pos_in),
   .slicer_neg_in(slicer_neg_in), .rx_rec_clk_in(rx_rec_clk_in),
   .rx_data_out(rx_data_out), .rx_positive_rail_out(rx_positive_rail_out),
   .rx_negative_rail_out(rx_negative_rail_out),
   .rx_powerdown_out(rx_powerdown_out));

// >>> test/test_e1c_top.sv
`timescale 1ns/1ns
module test_e1_template_ram_and_rx_config;
   reg clk_in = 1'b0;
   reg rstn_in = 1'b0;
   reg [7:0] a = 8'h00;
   reg [7:0] wd = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [5:0] shp = 6'h00;
   reg sp = 1'b0;
   reg sn = 1'b0;
   reg rck = 1'b0;
   wire [7:0] rdat;
   wire [7:0] amp;
   wire rxd;
   wire rxp;
   wire rxn;
   wire pd;
   integer miscompares = 0;
   integer n_compared = 0;
   integer i;
   reg [7:0] d;
   reg [6:0] mem [0:63];
   reg [5:0] adr [0:11];
   reg [5:0] scl;
   reg [5:0] ad;
   reg [4:0] cf;
   reg [2:0] rdv = 3'h0;
   reg [15:0] bm;
   reg [2:0] rx3;
   reg [2:0] ex;
   reg [31:0] rv;
   e1c_top e1c_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
      .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .shp_addr_in(shp), .shp_amp_out(amp),
      .slicer_pos_in(sp), .slicer_neg_in(sn), .rx_rec_clk_in(rck),
      .rx_data_out(rxd), .rx_positive_rail_out(rxp),
      .rx_negative_rail_out(rxn), .rx_powerdown_out(pd));
   // ------------------------------------------
   // Clock, bus tasks and expectations
   // ------------------------------------------
   initial
   begin
      forever #4 clk_in = ~clk_in;
   end
   // Recovered clock: eight clocks per bit, falls as rdv wraps to 0
   always @(posedge clk_in)
   begin
      rdv <= rdv + 3'h1;
      if (rdv[1:0] == 2'h3)
         rck <= ~rck;
   end
   task print_verdict;
   begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk(input [7:0] g, input [7:0] e);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task wrt(input [7:0] ra, input [7:0] v);
   begin
      @(posedge clk_in);
      a <= ra;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   end
   endtask
   task rdt(input [7:0] ra, output [7:0] v);
   begin
      @(posedge clk_in);
      a <= ra;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      v = rdat;
   end
   endtask
   task poll;
      integer k;
   begin
      k = 0;
      d = 8'h80;
      while (d[7] && k < 20)
      begin
         rdt(8'h08, d);
         k = k + 1;
      end
      if (d[7])
      begin
         miscompares = miscompares + 1;
         print_verdict;
      end
   end
   endtask
   function [7:0] sc(input [6:0] s, input [5:0] f);
      integer p;
   begin
      p = $signed(s) * $signed({1'b0, f}) * 31;
      sc = p >>> 10;
   end
   endfunction
   // Marks left after a same-polarity mark clears itself and three before
   function [15:0] dec_exp(input [15:0] p, input [15:0] n, input en);
      integer b;
      integer q;
      reg seen;
      reg lp;
   begin
      dec_exp = p ^ n;
      seen = 1'b0;
      lp = 1'b0;
      for (b = 0; b < 16; b = b + 1)
      begin
         if (p[b] ^ n[b])
         begin
            if (en && seen && p[b] == lp)
            begin
               for (q = b - 3; q <= b; q = q + 1)
               begin
                  if (q >= 0)
                     dec_exp[q] = 1'b0;
               end
            end
            seen = 1'b1;
            lp = p[b];
         end
      end
   end
   endfunction
   // One bit period: data moves two clocks after the falling edge
   task rxbit(input p, input n, output [2:0] o);
   begin
      repeat (2) @(posedge clk_in);
      sp <= p;
      sn <= n;
      repeat (5) @(posedge clk_in);
      #1;
      o = {rxd, rxp, rxn};
      @(posedge clk_in);
   end
   endtask
   task rxrun(input [4:0] c, input [15:0] pv, input [15:0] nv);
      integer k;
      integer j;
      integer q;
   begin
      bm = dec_exp(pv, nv, c[1:0] == 2'h0);
      sp <= 1'b0;
      sn <= 1'b0;
      wrt(8'h0a, 8'h10);
      wrt(8'h0a, {3'h0, c});
      k = 0;
      @(posedge clk_in);
      while (rdv != 3'h7 && k < 8)
      begin
         @(posedge clk_in);
         k = k + 1;
      end
      if (rdv != 3'h7)
      begin
         miscompares = miscompares + 1;
         print_verdict;
      end
      for (j = 0; j < 16; j = j + 1)
      begin
         rxbit(pv[j], nv[j], rx3);
         q = c[1] ? j : j - 4;
         if (c[2])
            q = q - 1;
         ex = {3{c[3]}};
         if (q >= 0 && c[1])
            ex = ex ^ {1'b0, pv[q], nv[q]};
         else if (q >= 0)
            ex = ex ^ {bm[q], 2'b00};
         chk({5'h0, rx3}, {5'h0, ex});
      end
   end
   endtask
   initial
   begin
      i = $urandom(32'h2c15964e);
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (i = 7; i < 12; i = i + 1)
      begin
         rdt(i[7:0], d);
         chk(d, i == 7 ? 8'h21 : 8'h00);
      end
      $display("reset test done");
      scl = $urandom;
      wrt(8'h07, {2'h3, scl});
      rdt(8'h07, d);
      chk(d, {2'h0, scl});
      for (i = 0; i < 12; i = i + 1)
      begin
         ad = i == 0 ? 6'h00 : (i == 1 ? 6'h3f : $urandom);
         adr[i] = ad;
         mem[ad] = $urandom;
         wrt(8'h09, {1'b1, mem[ad]});
         wrt(8'h08, {2'h2, ad});
         poll;
         chk(d, {2'h0, ad});
      end
      for (i = 0; i < 12; i = i + 1)
      begin
         ad = adr[i];
         wrt(8'h09, {1'b0, ~mem[ad]});
         shp <= ad;
         wrt(8'h08, {2'h3, ad});
         poll;
         chk(d, {2'h1, ad});
         rdt(8'h09, d);
         chk(d, {1'b0, mem[ad]});
         chk(amp, sc(mem[ad], scl));
      end
      $display("template test done");
      for (i = 0; i < 8; i = i + 1)
      begin
         cf = $urandom;
         cf[4] = i > 5;
         cf[1:0] = i > 6 ? cf[1:0] : 2'h3;
         wrt(8'h0a, {3'h7, cf});
         sp <= i[0];
         sn <= i[1] & ~i[0];
         rdt(8'h0a, d);
         chk(d, {3'h0, cf});
         chk({7'h0, pd}, {7'h0, cf[4]});
         repeat (10) @(posedge clk_in);
         #1;
         chk({5'h0, rxd, rxp, rxn}, {5'h0, cf[4] ? {3{cf[3]}} :
            {cf[3], sp ^ cf[3], sn ^ cf[3]}});
      end
      $display("receive test done");
      rxrun(5'h01, 16'h0011, 16'h0120);
      rxrun(5'h08, 16'h0011, 16'h0120);
      for (i = 0; i < 6; i = i + 1)
      begin
         rv = $urandom;
         cf = $urandom;
         cf[4] = 1'b0;
         cf[2] = i > 2;
         cf[1:0] = (i == 2 || i == 5) ? 2'h2 : {1'b0, i[0]};
         rxrun(cf, rv[15:0], rv[31:16] & ~rv[15:0]);
      end
      $display("decode test done");
      print_verdict;
   end
endmodule
